/* File: core/order_decode_sequencer.sv */
/*
 Central control: instruction-pair fetch, order decoding onto 36 lines, seven-pulse
 operations sequencer, order gates onto register clear and transfer buses, APB registers.
 Assumes memory and arithmetic on core_clk; memory acknowledges a request with mem_ack.
*/
`timescale 1ns/1ps
`include "order_map.svh"

// Functional notes
// RULE_01: Six code bits decode onto 36 lines.
// RULE_02: Line number equals binary code value.
// RULE_03: Seven pulses per pass, three variable.
// RULE_04: Variable pulse ends when operation completes.
// RULE_05: Memory pulse stretched until action done.
// RULE_06: Complex orders repeat the whole pass.
// RULE_07: Simple orders stop the pass early.
// RULE_08: Order gates AND line with pulse.
// RULE_09: Left shift: clear target, gate shifted.
// RULE_10: Fetch clears pair, reads counter address.
// RULE_11: Left instruction first, then right.
// RULE_12: Start signal launches each instruction.
// RULE_13: Left transfer abandons pair, fetches target.
// RULE_14: Right-half transfer skips new left instruction.
// RULE_15: Counter advances one per pair.
// RULE_16: Finish signal releases instruction control.
// RULE_17: Hold stretches second and third pulses.
// RULE_18: Gates set jump and jump-right flags.
// RULE_19: Cycle input repeats the pulse pass.
// RULE_20: Toggle pulse gives exactly two passes.
// RULE_21: Clear buses and straight/left/right transfers.
// RULE_22: Word holds two 20-bit instructions.
// RULE_23: Only six order bits reach decoder.
// RULE_24: Reset clears counter, fetches, sequencer idle.
// RULE_25: One pulse at a time, start needed.
module order_decode_sequencer (
	input wire logic core_clk,
	input wire logic rst_n,
	input order_pkg::apb_req_t apb_i,
	output order_pkg::apb_rsp_t apb_o,
	output order_pkg::mem_req_t mem_o,
	input wire logic mem_ack,
	input wire logic [`WORD_BITS-1:0] mem_rdata,
	input wire logic hold_in,
	input wire logic cycle_in,
	output order_pkg::gate_t gates_o,
	output logic [`PULSE_COUNT-1:0] timed_pulse_o,
	output logic finish_o
);
	import order_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Order gates

	function automatic gate_t order_gates(input logic [`LINE_COUNT-1:0] hit,
		input logic [`PULSE_COUNT-1:0] p);
		gate_t g;
		g = '0;
		// RULE_09 clear then shift
		if (hit[`LINE_SHIFT_L] & p[`P_T1]) begin
			g.clr0[`RB_TARGET] = 1'b1;
		end
		if (hit[`LINE_SHIFT_L] & p[`P_T2]) begin
			g.left = 1'b1;
			g.src = `RC_ACC;
			g.dst = `RC_TARGET;
			g.last = 1'b1;
		end
		// RULE_08 line and pulse
		if (hit[`LINE_LOAD] & p[`P_T1]) begin
			g.clr0[`RB_ACC] = 1'b1;
		end
		if (hit[`LINE_LOAD] & p[`P_T2]) begin
			g.mem_rd = 1'b1;
		end
		if (hit[`LINE_LOAD] & p[`P_T3]) begin
			g.straight = 1'b1;
			g.src = `RC_MEMBUF;
			g.dst = `RC_ACC;
			g.last = 1'b1;
		end
		if (hit[`LINE_STORE] & p[`P_T1]) begin
			g.straight = 1'b1;
			g.src = `RC_ACC;
			g.dst = `RC_MEMBUF;
		end
		if (hit[`LINE_STORE] & p[`P_T5]) begin
			g.mem_wr = 1'b1;
			g.last = 1'b1;
		end
		// RULE_18 jump flags
		if ((hit[`LINE_JUMP] | hit[`LINE_JUMP_R]) & p[`P_T1]) begin
			g.set_jump = 1'b1;
			g.set_jump_right = hit[`LINE_JUMP_R];
			g.last = 1'b1;
		end
		// RULE_21 all-ones clear bus
		if (hit[`LINE_ONES] & p[`P_T1]) begin
			g.clr1[`RB_ACC] = 1'b1;
			g.last = 1'b1;
		end
		if (hit[`LINE_DOUBLE] & p[`P_T2]) begin
			g.right = 1'b1;
			g.src = `RC_ACC;
			g.dst = `RC_FIRST;
		end
		// RULE_20 start toggle
		if (hit[`LINE_DOUBLE] & p[`P_T6]) begin
			g.toggle = 1'b1;
		end
		// RULE_07 early stop
		if (p[`P_T1] & ~(hit[`LINE_LOAD] | hit[`LINE_STORE] | hit[`LINE_SHIFT_L]
			| hit[`LINE_DOUBLE])) begin
			g.last = 1'b1;
		end
		return g;
	endfunction : order_gates

	////////////////////////////////////////////////////////////////////////////////
	// Order matrix

	logic [`CODE_BITS-1:0] order_q, order_d;
	logic [`LINE_COUNT-1:0] line_hit;

	function automatic logic [`CODE_BITS-1:0] code_of(input logic [`ORDER_BITS-1:0] o);
		// RULE_23 drop leading tetrad ones
		return {o[`ORD_UPPER_F], o[`ORD_LOWER_F]};
	endfunction : code_of

	// RULE_01 one gate per line
	for (genvar i = 0; i < `LINE_COUNT; i++) begin : g_line
		// RULE_02 binary ordered match
		assign line_hit[i] = (order_q == `CODE_BITS'(i));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operations sequencer

	seq_state_t seq_q, seq_d;
	logic [`PULSE_COUNT-1:0] pulse_q, pulse_d;
	logic [`CNT_BITS-1:0] cnt_q, cnt_d;
	logic toggle_q, toggle_d;
	gate_t gates_q, gates_d;
	logic seq_start, seq_finish, pulse_end, pass_end, mem_ok, variable_p, stretch;
	logic toggle_next;

	always_comb begin
		seq_d = seq_q;
		pulse_d = pulse_q;
		cnt_d = cnt_q;
		toggle_d = toggle_q;
		seq_finish = 1'b0;
		// RULE_05 wait for memory action
		mem_ok = ~(gates_q.mem_rd | gates_q.mem_wr) | mem_ack;
		// RULE_03 three variable pulses
		variable_p = pulse_q[`P_T2] | pulse_q[`P_T3] | pulse_q[`P_T5];
		// RULE_17 hold stretch
		stretch = hold_in & (pulse_q[`P_T2] | pulse_q[`P_T3]);
		// RULE_04 end on completion
		if (variable_p) begin
			pulse_end = mem_ok & ~stretch;
		end else begin
			pulse_end = mem_ok & (cnt_q == `CNT_BITS'(`FIXED_PULSE_CYC - 1));
		end
		toggle_next = toggle_q ^ gates_q.toggle;
		pass_end = pulse_end & (gates_q.last | pulse_q[`P_T7]);
		unique case (seq_q)
			SEQ_IDLE: begin
				// RULE_25 wait for start
				if (seq_start) begin
					seq_d = SEQ_RUN;
					pulse_d = `PULSE_FIRST;
					cnt_d = '0;
					toggle_d = 1'b0;
				end
			end
			SEQ_RUN: begin
				if (pass_end) begin
					// RULE_06 repeat pass
					// RULE_19 cycle input
					if (cycle_in | toggle_next) begin
						pulse_d = `PULSE_FIRST;
						toggle_d = toggle_next;
					end else begin
						// RULE_16 finish signal
						seq_d = SEQ_IDLE;
						pulse_d = '0;
						toggle_d = 1'b0;
						seq_finish = 1'b1;
					end
					cnt_d = '0;
				end else if (pulse_end) begin
					// RULE_25 one-hot advance
					pulse_d = pulse_q << 1;
					cnt_d = '0;
					toggle_d = toggle_next;
				end else begin
					cnt_d = cnt_q + `CNT_BITS'(1);
				end
			end
		endcase
		gates_d = order_gates(line_hit, pulse_d);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// RULE_24 sequencer idle
			seq_q <= SEQ_IDLE;
			pulse_q <= '0;
			cnt_q <= '0;
			toggle_q <= 1'b0;
			gates_q <= '0;
		end else begin
			seq_q <= seq_d;
			pulse_q <= pulse_d;
			cnt_q <= cnt_d;
			toggle_q <= toggle_d;
			gates_q <= gates_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Instruction control

	ic_state_t ic_q, ic_d;
	logic [`ADDR_BITS-1:0] pc_q, pc_d, addr_q, addr_d;
	logic [`WORD_BITS-1:0] pair_q, pair_d;
	logic jump_q, jump_d, jright_q, jright_d, skip_q, skip_d, jump_now, jright_now;
	logic run_q, wr_pc;
	logic [31:0] pwdata_w;
	mem_req_t mem_q, mem_d;

	// RULE_12 start pulse
	assign seq_start = (ic_q == IC_LEFT_START) | (ic_q == IC_RIGHT_START);

	always_comb begin
		ic_d = ic_q;
		pc_d = pc_q;
		addr_d = addr_q;
		pair_d = pair_q;
		order_d = order_q;
		skip_d = skip_q;
		// RULE_18 gate set seen same cycle; clear on finish wins over it
		jump_now = jump_q | gates_q.set_jump;
		jright_now = jright_q | gates_q.set_jump_right;
		jump_d = jump_now;
		jright_d = jright_now;
		unique case (ic_q)
			IC_FETCH: begin
				// RULE_10 clear pair
				pair_d = '0;
				if (run_q) begin
					ic_d = IC_FETCH_WAIT;
				end
				if (wr_pc) begin
					pc_d = pwdata_w[`ADDR_BITS-1:0];
				end
			end
			IC_FETCH_WAIT: begin
				if (mem_ack) begin
					// RULE_22 two instructions per word
					pair_d = mem_rdata;
					skip_d = 1'b0;
					// RULE_14 skip left half
					if (skip_q) begin
						ic_d = IC_RIGHT_START;
						order_d = code_of(mem_rdata[`RIGHT_ORDER_F]);
						addr_d = mem_rdata[`RIGHT_ADDR_F];
						// RULE_15 advance counter
						pc_d = pc_q + `ADDR_BITS'(1);
					end else begin
						// RULE_11 left first
						ic_d = IC_LEFT_START;
						order_d = code_of(mem_rdata[`LEFT_ORDER_F]);
						addr_d = mem_rdata[`LEFT_ADDR_F];
					end
				end
			end
			IC_LEFT_START: begin
				ic_d = IC_LEFT_WAIT;
			end
			IC_LEFT_WAIT: begin
				// RULE_16 wait for finish
				if (seq_finish) begin
					if (jump_now) begin
						// RULE_13 abandon pair
						pc_d = addr_q;
						skip_d = jright_now;
						jump_d = 1'b0;
						jright_d = 1'b0;
						ic_d = IC_FETCH;
					end else begin
						// RULE_11 then right
						ic_d = IC_RIGHT_START;
						order_d = code_of(pair_q[`RIGHT_ORDER_F]);
						addr_d = pair_q[`RIGHT_ADDR_F];
						// RULE_15 advance counter
						pc_d = pc_q + `ADDR_BITS'(1);
					end
				end
			end
			IC_RIGHT_START: begin
				ic_d = IC_RIGHT_WAIT;
			end
			IC_RIGHT_WAIT: begin
				if (seq_finish) begin
					if (jump_now) begin
						pc_d = addr_q;
						skip_d = jright_now;
					end
					jump_d = 1'b0;
					jright_d = 1'b0;
					ic_d = IC_FETCH;
				end
			end
			default: begin
				ic_d = IC_FETCH;
			end
		endcase
		// RULE_10 counter to memory address
		mem_d.req = (ic_d == IC_FETCH_WAIT) | gates_d.mem_rd | gates_d.mem_wr;
		mem_d.we = gates_d.mem_wr;
		mem_d.addr = (ic_d == IC_FETCH_WAIT) ? pc_d : addr_d;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// RULE_24 clear counter, fetch
			ic_q <= IC_FETCH;
			pc_q <= '0;
			addr_q <= '0;
			pair_q <= '0;
			order_q <= '0;
			jump_q <= 1'b0;
			jright_q <= 1'b0;
			skip_q <= 1'b0;
			mem_q <= '0;
		end else begin
			ic_q <= ic_d;
			pc_q <= pc_d;
			addr_q <= addr_d;
			pair_q <= pair_d;
			order_q <= order_d;
			jump_q <= jump_d;
			jright_q <= jright_d;
			skip_q <= skip_d;
			mem_q <= mem_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB registers

	logic [31:0] prdata_q, prdata_d;
	logic run_d, setup_ph, access_ph, mapped;

	assign pwdata_w = apb_i.pwdata;
	assign setup_ph = apb_i.psel & ~apb_i.penable;
	assign access_ph = apb_i.psel & apb_i.penable;
	assign wr_pc = access_ph & apb_i.pwrite & (apb_i.paddr == `APB_PC) & ~run_q;

	always_comb begin
		run_d = run_q;
		prdata_d = prdata_q;
		mapped = 1'b1;
		unique case (apb_i.paddr)
			`APB_CTRL, `APB_STATUS, `APB_PC, `APB_PAIR_LO, `APB_PAIR_HI, `APB_ORDER: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (setup_ph & ~apb_i.pwrite) begin
			unique case (apb_i.paddr)
				`APB_CTRL: prdata_d = 32'(run_q);
				`APB_STATUS: prdata_d = 32'({ic_q, seq_q, pulse_q, toggle_q, jump_q, jright_q,
					skip_q});
				`APB_PC: prdata_d = 32'(pc_q);
				`APB_PAIR_LO: prdata_d = pair_q[`PAIR_LO_F];
				`APB_PAIR_HI: prdata_d = 32'(pair_q[`PAIR_HI_F]);
				`APB_ORDER: prdata_d = 32'({|line_hit, order_q});
				default: prdata_d = '0;
			endcase
		end
		if (access_ph & apb_i.pwrite & (apb_i.paddr == `APB_CTRL)) begin
			run_d = apb_i.pwdata[`CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_q <= `CTRL_RUN_RESET;
			prdata_q <= '0;
		end else begin
			run_q <= run_d;
			prdata_q <= prdata_d;
		end
	end

	assign apb_o.prdata = prdata_q;
	assign apb_o.pready = access_ph;
	assign apb_o.pslverr = access_ph & ~mapped;

	assign mem_o = mem_q;
	// RULE_21 registered clear and transfer buses
	assign gates_o = gates_q;
	assign timed_pulse_o = pulse_q;
	assign finish_o = seq_finish;

endmodule : order_decode_sequencer

/* File: core/order_map.svh */
/*
 Constants of the order decoder and sequencer: timing, field positions, order lines,
 register bit positions and APB register offsets.
 Assumes inclusion by the package and by the design module.
*/
`ifndef ORDER_MAP_SVH
`define ORDER_MAP_SVH

`define CLK_PERIOD_NS 40
`define FIXED_PULSE_NS 80
`define FIXED_PULSE_CYC ((`FIXED_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_COUNT 7
`define PULSE_FIRST 7'h01
`define P_T1 0
`define P_T2 1
`define P_T3 2
`define P_T5 4
`define P_T6 5
`define P_T7 6
`define CNT_BITS 3

`define WORD_BITS 40
`define ADDR_BITS 10
`define ORDER_BITS 8
`define CODE_BITS 6
`define LINE_COUNT 36
`define LEFT_ORDER_F 39:32
`define LEFT_ADDR_F 29:20
`define RIGHT_ORDER_F 19:12
`define RIGHT_ADDR_F 9:0
`define ORD_UPPER_F 6:4
`define ORD_LOWER_F 2:0
`define PAIR_LO_F 31:0
`define PAIR_HI_F 39:32

`define LINE_LOAD 0
`define LINE_STORE 1
`define LINE_SHIFT_L 2
`define LINE_JUMP 3
`define LINE_JUMP_R 4
`define LINE_DOUBLE 5
`define LINE_ONES 6

`define REG_COUNT 6
`define RB_FIRST 0
`define RB_ACC 1
`define RB_TARGET 2
`define RC_FIRST 3'h1
`define RC_ACC 3'h2
`define RC_TARGET 3'h3
`define RC_MEMBUF 3'h5

`define APB_ADDR_BITS 12
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define APB_PC 12'h008
`define APB_PAIR_LO 12'h00C
`define APB_PAIR_HI 12'h010
`define APB_ORDER 12'h014
`define CTRL_RUN_BIT 0
`define CTRL_RUN_RESET 1'b1

`endif

/* File: core/order_pkg.sv */
/*
 Types of the order decoder and sequencer: state enums and the packed carriers
 of the APB port, the memory request and the order gate outputs.
 Assumes order_map.svh on the include path.
*/
`include "order_map.svh"

package order_pkg;

	typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_t;

	typedef enum logic [2:0] {
		IC_FETCH, IC_FETCH_WAIT, IC_LEFT_START, IC_LEFT_WAIT, IC_RIGHT_START, IC_RIGHT_WAIT
	} ic_state_t;

	typedef struct packed {
		logic [`REG_COUNT-1:0] clr0;
		logic [`REG_COUNT-1:0] clr1;
		logic straight;
		logic left;
		logic right;
		logic [2:0] src;
		logic [2:0] dst;
		logic mem_rd;
		logic mem_wr;
		logic set_jump;
		logic set_jump_right;
		logic toggle;
		logic last;
	} gate_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [`ADDR_BITS-1:0] addr;
	} mem_req_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`APB_ADDR_BITS-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage : order_pkg

/* File: test/order_checker.sv */
/*
 Port assertions of the order decoder and sequencer.
 Assumes binding onto order_decode_sequencer, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "order_map.svh"
module order_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input order_pkg::apb_req_t apb_i,
	input order_pkg::apb_rsp_t apb_o,
	input order_pkg::mem_req_t mem_o,
	input wire logic mem_ack,
	input wire logic [`WORD_BITS-1:0] mem_rdata,
	input wire logic hold_in,
	input wire logic cycle_in,
	input order_pkg::gate_t gates_o,
	input wire logic [`PULSE_COUNT-1:0] timed_pulse_o,
	input wire logic finish_o
);
	import order_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	property p_one_pulse;
		$onehot0(timed_pulse_o);
	endproperty
	a_one_pulse: assert property (p_one_pulse)
		else $error("more than one pulse");
	property p_t1_fixed;
		$rose(timed_pulse_o[0]) |-> timed_pulse_o[0] [*2] ##1 !timed_pulse_o[0];
	endproperty
	a_t1_fixed: assert property (p_t1_fixed)
		else $error("first pulse not two cycles");
	property p_hold;
		timed_pulse_o[1] && hold_in |=> timed_pulse_o[1];
	endproperty
	a_hold: assert property (p_hold)
		else $error("second pulse ended under hold");
	property p_var_mem;
		gates_o.mem_rd && mem_o.req && !mem_ack |=> $stable(timed_pulse_o);
	endproperty
	a_var_mem: assert property (p_var_mem)
		else $error("memory pulse ended early");
	property p_req_stand;
		mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we);
	endproperty
	a_req_stand: assert property (p_req_stand)
		else $error("memory request dropped before ack");
	property p_fetch_t1;
		mem_o.req && mem_ack && timed_pulse_o == 0 |-> ##3 timed_pulse_o[0];
	endproperty
	a_fetch_t1: assert property (p_fetch_t1)
		else $error("no start after fetch");
	property p_finish;
		finish_o |-> timed_pulse_o != 0 ##1 (timed_pulse_o == 0 && !finish_o);
	endproperty
	a_finish: assert property (p_finish)
		else $error("finish not at last pulse");
	property p_gate_pulse;
		gates_o.left || gates_o.right || gates_o.straight |-> timed_pulse_o != 0;
	endproperty
	a_gate_pulse: assert property (p_gate_pulse)
		else $error("transfer gate outside pulse");
	c_finish: cover property (finish_o);
	c_hold: cover property (timed_pulse_o[1] && hold_in);
	c_mem: cover property (gates_o.mem_rd && mem_ack);
	c_double: cover property (gates_o.toggle);
endmodule : order_checker

bind order_decode_sequencer order_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.apb_i(apb_i), .apb_o(apb_o), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
	.hold_in(hold_in), .cycle_in(cycle_in), .gates_o(gates_o),
	.timed_pulse_o(timed_pulse_o), .finish_o(finish_o));

/* File: test/mem_model.sv */
/*
 Memory partner: holds a small program, acknowledges requests promptly or slowly.
 Assumes core_clk shared with the decoder.
*/
`timescale 1ns/1ps
`include "order_map.svh"
module mem_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input order_pkg::mem_req_t mem_o,
	output logic mem_ack,
	output logic [`WORD_BITS-1:0] mem_rdata
);
	import order_pkg::*;
	logic ack_q = 1'b0;
	logic slow_q = 1'b0;
	logic [2:0] wait_q = 3'h0;
	logic [`WORD_BITS-1:0] data_q = '0;
	assign mem_ack = ack_q;
	assign mem_rdata = data_q;
	function automatic logic [`WORD_BITS-1:0] word_at(input logic [`ADDR_BITS-1:0] a);
		case (a)
			10'h000: word_at = 40'h8A00088007;
			10'h001: word_at = 40'h8B00488000;
			10'h004: word_at = 40'h8C00688000;
			10'h006: word_at = 40'h880098800A;
			10'h007: word_at = 40'h890108D000;
			10'h008: word_at = 40'h8E00088000;
			default: word_at = 40'h8800088000;
		endcase
	endfunction : word_at
	////////////////////////////////////////////////////////////////
	// prompt acknowledge first, regeneration wait on every other request
	always @(posedge core_clk) begin
		if (!rst_n || ack_q || !mem_o.req) begin
			ack_q <= 1'b0;
			wait_q <= 3'h0;
			data_q <= ~data_q;
			if (ack_q)
				slow_q <= !slow_q;
		end else if (wait_q == (slow_q ? 3'h3 : 3'h0)) begin
			ack_q <= 1'b1;
			data_q <= word_at(mem_o.addr);
		end else begin
			wait_q <= wait_q + 3'h1;
			data_q <= ~data_q;
		end
	end
endmodule : mem_model

/* File: test/order_decode_sequencer_tb_top.sv */
/*
 Testbench: runs a short program through the decoder and checks pulses, gates,
 fetch order and APB registers. Assumes mem_model as memory.
*/
`timescale 1ns/1ps
`include "order_map.svh"
module order_decode_sequencer_tb_top;
	import order_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hold_in = 1'b0;
	logic cycle_in = 1'b0;
	apb_req_t apb_q = '0;
	apb_rsp_t apb_o;
	mem_req_t mem_o;
	logic mem_ack;
	logic [`WORD_BITS-1:0] mem_rdata;
	gate_t gates_o;
	logic [`PULSE_COUNT-1:0] timed_pulse_o;
	logic finish_o;
	int fail_count = 0;
	int cmp_count = 0;
	logic [`ADDR_BITS-1:0] ack_log[$];
	always #20 core_clk = ~core_clk;
	order_decode_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .apb_i(apb_q),
		.apb_o(apb_o), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.hold_in(hold_in), .cycle_in(cycle_in), .gates_o(gates_o),
		.timed_pulse_o(timed_pulse_o), .finish_o(finish_o));
	mem_model u_mem (.core_clk(core_clk), .rst_n(rst_n), .mem_o(mem_o), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	always @(posedge core_clk)
		if (rst_n && mem_o.req && mem_ack)
			ack_log.push_back(mem_o.addr);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d,
		input logic err);
		apb_q <= '{1'b1, 1'b0, we, a, we ? d : 32'h0};
		@(posedge core_clk);
		apb_q.penable <= 1'b1;
		// Ends on pready; only the watchdog bounds this wait
		do begin
			@(posedge core_clk);
		end while (apb_o.pready !== 1'b1);
		chk(apb_o.pready, 1);
		chk(apb_o.pslverr, err);
		if (!we)
			chk(apb_o.prdata, d);
		apb_q <= '0;
		// Idle edge before the next setup
		@(posedge core_clk);
	endtask : apb
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		int n;
		chk(timed_pulse_o, 0);
		for (n = 0; n < 50 && mem_o.req !== 1'b1; n++)
			@(negedge core_clk);
		chk(mem_o.addr, 0);
		chk(mem_o.we, 0);
	endtask : t_reset
	task automatic t_shift;
		int n;
		for (n = 0; n < 50 && timed_pulse_o[0] !== 1'b1; n++)
			@(negedge core_clk);
		chk(gates_o.clr0[`RB_TARGET], 1);
		@(posedge core_clk);
		hold_in <= 1'b1;
		for (n = 0; n < 50 && timed_pulse_o[1] !== 1'b1; n++)
			@(negedge core_clk);
		chk({gates_o.left, gates_o.src, gates_o.dst}, {1'b1, `RC_ACC, `RC_TARGET});
		repeat (4) @(negedge core_clk);
		chk(timed_pulse_o, 7'h02);
		@(posedge core_clk);
		hold_in <= 1'b0;
		cycle_in <= 1'b1;
		@(negedge core_clk);
		chk(finish_o, 0);
		@(posedge core_clk);
		cycle_in <= 1'b0;
		@(negedge core_clk);
		chk(timed_pulse_o, 7'h01);
		for (n = 0; n < 50 && finish_o !== 1'b1; n++)
			@(negedge core_clk);
		chk(timed_pulse_o, 7'h02);
		@(negedge core_clk);
		chk(timed_pulse_o, 0);
	endtask : t_shift
	task automatic t_apb;
		apb(1'b0, `APB_CTRL, 32'h1, 1'b0);
		apb(1'b1, `APB_CTRL, 32'h1, 1'b0);
		apb(1'b0, 12'h020, 32'h0, 1'b1);
	endtask : t_apb
	task automatic t_flow;
		logic [9:0] exp_q[6] = '{10'h000, 10'h007, 10'h001, 10'h004, 10'h006, 10'h00A};
		int n;
		for (n = 0; n < 400 && ack_log.size() < 6; n++)
			@(negedge core_clk);
		for (n = 0; n < 6; n++)
			chk(ack_log[n], exp_q[n]);
	endtask : t_flow
	task automatic t_orders;
		int n;
		int rises;
		logic prev;
		rises = 0;
		prev = 1'b0;
		for (n = 0; n < 400 && gates_o.mem_wr !== 1'b1; n++)
			@(negedge core_clk);
		chk({mem_o.req, mem_o.we, mem_o.addr}, {2'b11, 10'h010});
		chk(timed_pulse_o, 7'h10);
		for (n = 0; n < 50 && finish_o !== 1'b1; n++)
			@(negedge core_clk);
		for (n = 0; n < 100; n++) begin
			@(negedge core_clk);
			if (timed_pulse_o[`P_T1] && !prev)
				rises++;
			prev = timed_pulse_o[`P_T1];
			if (gates_o.right === 1'b1)
				chk({gates_o.src, gates_o.dst}, {`RC_ACC, `RC_FIRST});
			if (finish_o === 1'b1)
				break;
		end
		chk(rises, 2);
		for (n = 0; n < 100 && gates_o.clr1[`RB_ACC] !== 1'b1; n++)
			@(negedge core_clk);
		chk(timed_pulse_o, 7'h01);
		for (n = 0; n < 50 && finish_o !== 1'b1; n++)
			@(negedge core_clk);
		chk(timed_pulse_o, 7'h01);
	endtask : t_orders
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_shift();
		@(posedge core_clk);
		t_apb();
		t_flow();
		t_orders();
		end_of_test();
	end
	// Watchdog: whole run needs well under a thousand cycles
	initial begin
		#400000;
		fail_count++;
		end_of_test();
	end
endmodule : order_decode_sequencer_tb_top
